// ==== xrs_pkg.sv ====
// Purpose: constants for the resampler/transmitter status and interrupt block
// Assumes: byte-wide registers reached over a simple host register port
// Notes: offsets are register indices on the serial control port
package xrs_pkg;
  localparam logic [7:0] ADDR_TX_CTRL1 = 8'h07;
  localparam logic [7:0] ADDR_TX_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_TX_SRC_CFG = 8'h09;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h0b;
  localparam logic [7:0] ADDR_EVENT_TRIG = 8'h0c;
  localparam logic [7:0] ADDR_SUMMARY = 8'h02;
  // event bit positions, shared by status and mask
  localparam int BIT_COPY = 0;
  localparam int BIT_SLIP = 1;
  localparam int BIT_READY = 4;
  localparam int BIT_RATIO = 5;
  // control register 0x07 fields
  localparam int BIT_SLIP_SEL = 0;
  localparam int BIT_VALID = 1;
  // control register 0x08 fields
  localparam int BIT_COPY_DIS = 3;
  localparam int BIT_BYP_LO = 6;
  // source configuration fields
  localparam int BIT_VAL_SRC = 2;
  // summary register bits
  localparam int BIT_SUM_TX = 0;
  localparam int BIT_SUM_RS = 1;
  localparam logic [7:0] EVENT_BITS = 8'h33;
  localparam logic [7:0] SRC_CFG_BITS = 8'h07;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int HOST_BYTES = 10;
  typedef enum logic [1:0] {
    TRIG_RISE,
    TRIG_FALL,
    TRIG_LEVEL,
    TRIG_RSVD
  } xrs_trig_t;
  typedef enum logic [1:0] {
    CU_NONE,
    CU_HOST,
    CU_CAPTURE,
    CU_SPLIT
  } xrs_cu_src_t;
endpackage

// ==== xrs_event_cell.sv ====
// Purpose: one event flag with trigger-mode selection and mask gating
// Assumes: cond_i already synchronised to mclk_i
// Notes: edge flags are sticky until a status read; level flags follow cond
`timescale 1ns/1ps
module xrs_event_cell (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cond_i,
  input wire logic mask_i,
  input wire logic [1:0] mode_i,
  input wire logic clear_i,
  output logic flag_o
);
  import xrs_pkg::*;
  logic cond_q;
  logic hit;

  // previous condition for edge detection
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= cond_i;
    end
  end

  // reserved mode triggers nothing; host must not pick it
  always_comb begin
    case (xrs_trig_t'(mode_i))
      TRIG_RISE: hit = cond_i & ~cond_q;
      TRIG_FALL: hit = ~cond_i & cond_q;
      TRIG_LEVEL: hit = cond_i;
      default: hit = 1'b0;
    endcase
  end

  // a new event in the clearing cycle wins over the read clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (!mask_i) begin
      flag_o <= 1'b0;
    end else if (xrs_trig_t'(mode_i) == TRIG_LEVEL) begin
      flag_o <= cond_i;
    end else if (hit) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end

  rising_sets_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mask_i && mode_i == 2'b00 && cond_i && !cond_q) |=> flag_o)
    else $error("rising edge did not set flag");
  masked_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mask_i |=> !flag_o)
    else $error("masked flag is set");
  level_follow_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mask_i && mode_i == 2'b10) |=> (flag_o == $past(cond_i)))
    else $error("level flag does not follow condition");
endmodule

// ==== xrs_status_irq.sv ====
// Purpose: event status, mask, trigger mode and transmitter source control
// Summary of operation
// - bypass select picks receiver one to four
// - source field 00 blocks all buffer updates
// - 01 host writes only; 10 capture loads
// - 11 first ten bytes host, rest capture
// - validity from control bit or receiver passthrough
// - copy-done flag on completed transfer, enabled, unmasked
// - slip flag on slip or block start
// - copy or slip flag drives interrupt, tx summary
// - estimator-ready flag when both estimators finish
// - ratio flag while input rate exceeds output
// - ready or ratio flag drives interrupt, summary
// - status layout bits 5,4,1,0; others zero
// - mask bits per source, zero masks
// - trigger mode rise, fall, level, reserved
// - trigger mode field positions per source
// - source config upper bits zero, fields low
// - slip select zero slip, one block start
// - ratio trigger mode uses same encoding
// Assumes: serial control port already decoded into byte read/write strobes
// Notes: events from other clock domains pass three flip-flops
`timescale 1ns/1ps
module xrs_status_irq (
  input wire logic mclk_i,
  input wire logic rst_i,
  // host register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // raw event conditions from other clock domains
  input wire logic copy_done_i,
  input wire logic data_slip_i,
  input wire logic block_start_i,
  input wire logic est_in_done_i,
  input wire logic est_out_done_i,
  input wire logic rate_in_gt_out_i,
  // buffer byte write requests
  input wire logic [7:0] buf_byte_idx_i,
  input wire logic host_buf_wr_i,
  input wire logic capture_buf_wr_i,
  output logic buf_wr_en_o,
  output logic buf_from_host_o,
  // validity and bypass
  input wire logic rx_validity_i,
  input wire logic [3:0] line_rx_i,
  output logic tx_validity_o,
  output logic bypass_data_o,
  output logic copy_disable_o,
  output logic int_n_o
);
  import xrs_pkg::*;
  logic [7:0] tx_ctrl1;
  logic [7:0] tx_ctrl2;
  logic [7:0] src_cfg;
  logic [7:0] event_mask;
  logic [7:0] event_trig;
  logic [7:0] event_status;
  logic [7:0] summary;
  logic [5:0] raw;
  logic [5:0] s1;
  logic [5:0] s2;
  logic [5:0] s3;
  logic [5:0] stable;
  logic [3:0] cond;
  logic [3:0] flag;
  logic status_rd;
  logic [1:0] byp_sel;
  logic [1:0] cu_src;
  logic next_wr_en;
  logic next_from_host;

  assign raw = {rate_in_gt_out_i, est_out_done_i, est_in_done_i,
                block_start_i, data_slip_i, copy_done_i};

  // three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      stable <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      stable <= (s2 & s3) | (stable & (s2 | s3));
    end
  end

  // host register writes; unused mask and source config bits stored as zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_ctrl1 <= RESET_BYTE;
      tx_ctrl2 <= RESET_BYTE;
      src_cfg <= RESET_BYTE;
      event_mask <= RESET_BYTE;
      event_trig <= RESET_BYTE;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_TX_CTRL1) begin
        tx_ctrl1 <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_TX_CTRL2) begin
        tx_ctrl2 <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_TX_SRC_CFG) begin
        src_cfg <= reg_wdata_i & SRC_CFG_BITS;
      end else if (reg_addr_i == ADDR_EVENT_MASK) begin
        event_mask <= reg_wdata_i & EVENT_BITS;
      end else if (reg_addr_i == ADDR_EVENT_TRIG) begin
        event_trig <= reg_wdata_i;
      end
    end
  end

  assign byp_sel = tx_ctrl2[BIT_BYP_LO +: 2];
  assign cu_src = src_cfg[1:0];

  // per-source event conditions
  always_comb begin
    cond[0] = stable[0] & ~tx_ctrl2[BIT_COPY_DIS];
    cond[1] = tx_ctrl1[BIT_SLIP_SEL] ? stable[2] : stable[1];
    cond[2] = stable[3] & stable[4];
    cond[3] = stable[5];
  end

  assign status_rd = reg_rd_i && (reg_addr_i == ADDR_EVENT_STATUS);

  // one cell per source; mode field pairs sit at 2*i
  localparam int POS [4] = '{BIT_COPY, BIT_SLIP, BIT_READY, BIT_RATIO};
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ev
      xrs_event_cell u_cell (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i(cond[i]),
        .mask_i(event_mask[POS[i]]),
        .mode_i(event_trig[2*i +: 2]),
        .clear_i(status_rd),
        .flag_o(flag[i])
      );
    end
  endgenerate

  // status layout with zero in unused bits
  always_comb begin
    event_status = 8'h00;
    event_status[BIT_COPY] = flag[0];
    event_status[BIT_SLIP] = flag[1];
    event_status[BIT_READY] = flag[2];
    event_status[BIT_RATIO] = flag[3];
    summary = 8'h00;
    summary[BIT_SUM_TX] = flag[0] | flag[1];
    summary[BIT_SUM_RS] = flag[2] | flag[3];
  end

  // interrupt low while any flag stands; flags are already mask-gated
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= ~|flag;
    end
  end

  // read data registered; unmapped reads return zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ADDR_TX_CTRL1) begin
        reg_rdata_o <= tx_ctrl1;
      end else if (reg_addr_i == ADDR_TX_CTRL2) begin
        reg_rdata_o <= tx_ctrl2;
      end else if (reg_addr_i == ADDR_TX_SRC_CFG) begin
        reg_rdata_o <= src_cfg;
      end else if (reg_addr_i == ADDR_EVENT_STATUS) begin
        reg_rdata_o <= event_status;
      end else if (reg_addr_i == ADDR_EVENT_MASK) begin
        reg_rdata_o <= event_mask;
      end else if (reg_addr_i == ADDR_EVENT_TRIG) begin
        reg_rdata_o <= event_trig;
      end else if (reg_addr_i == ADDR_SUMMARY) begin
        reg_rdata_o <= summary;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // host-side buffer write gating by source field
  always_comb begin
    next_wr_en = 1'b0;
    next_from_host = 1'b0;
    case (xrs_cu_src_t'(cu_src))
      CU_NONE: begin
        next_wr_en = 1'b0;
      end
      CU_HOST: begin
        next_wr_en = host_buf_wr_i;
        next_from_host = 1'b1;
      end
      CU_CAPTURE: begin
        next_wr_en = capture_buf_wr_i;
      end
      default: begin
        // split point sits at a fixed byte index
        next_from_host = buf_byte_idx_i < 8'(HOST_BYTES);
        next_wr_en = next_from_host ? host_buf_wr_i : capture_buf_wr_i;
      end
    endcase
  end

  // buffer strobe, validity and bypass all registered outputs
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      buf_wr_en_o <= 1'b0;
      buf_from_host_o <= 1'b0;
      tx_validity_o <= 1'b0;
      bypass_data_o <= 1'b0;
      copy_disable_o <= 1'b0;
    end else begin
      buf_wr_en_o <= next_wr_en;
      buf_from_host_o <= next_from_host;
      // one register stage; same cycle as the control-bit path
      tx_validity_o <= src_cfg[BIT_VAL_SRC] ? rx_validity_i
                                            : tx_ctrl1[BIT_VALID];
      bypass_data_o <= line_rx_i[byp_sel];
      copy_disable_o <= tx_ctrl2[BIT_COPY_DIS];
    end
  end

  no_update_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cu_src == 2'b00) |=> !buf_wr_en_o)
    else $error("buffer written with source field zero");
  split_host_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cu_src == 2'b11 && buf_byte_idx_i < 8'd10) |=> buf_from_host_o)
    else $error("early byte not from host");
  split_cap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cu_src == 2'b11 && buf_byte_idx_i >= 8'd10) |=> !buf_from_host_o)
    else $error("late byte not from capture");
  host_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cu_src == 2'b01) |=> (buf_wr_en_o == $past(host_buf_wr_i)))
    else $error("host mode write mismatch");
  validity_src_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> tx_validity_o == ($past(src_cfg[2]) ? $past(rx_validity_i)
                                                 : $past(tx_ctrl1[1])))
    else $error("validity source wrong");
  bypass_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> bypass_data_o == $past(line_rx_i[byp_sel]))
    else $error("bypass source wrong");
  irq_low_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (|flag) |=> !int_n_o)
    else $error("interrupt not asserted");
  irq_release_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(|flag) |=> int_n_o)
    else $error("interrupt not released");
  status_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (event_status & 8'hcc) == 8'h00)
    else $error("reserved status bit set");
  copy_dis_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tx_ctrl2[3] && !flag[0]) |=> !flag[0] || event_trig[1:0] == 2'b11)
    else $error("copy flag set while disabled");
  cap_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cu_src == 2'b10) |=> (buf_wr_en_o == $past(capture_buf_wr_i)))
    else $error("capture mode write mismatch");
  cap_src_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cu_src == 2'b10) |=> !buf_from_host_o)
    else $error("capture mode source wrong");
  host_src_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cu_src == 2'b01) |=> buf_from_host_o)
    else $error("host mode source wrong");
  // register writes keep only the bits that exist; a stray bit would misroute events
  mask_wr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == ADDR_EVENT_MASK) |=>
      (event_mask == ($past(reg_wdata_i) & 8'h33)))
    else $error("mask register kept a reserved bit");
  cfg_wr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == ADDR_TX_SRC_CFG) |=>
      (src_cfg == ($past(reg_wdata_i) & 8'h07)))
    else $error("source config kept a reserved bit");
  trig_wr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == ADDR_EVENT_TRIG) |=>
      (event_trig == $past(reg_wdata_i)))
    else $error("trigger mode register not stored");
  status_rd_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    status_rd |=> (reg_rdata_o == $past(event_status)))
    else $error("status read returned wrong flags");
  copy_dis_o_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> (copy_disable_o == $past(tx_ctrl2[3])))
    else $error("copy disable output wrong");
  // a synchronised bit may only move once stages two and three agree
  sync_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> ((($past(s2) ^ $past(s3)) & (stable ^ $past(stable))) == 6'h00))
    else $error("event moved before synchroniser agreed");

  irq_seen_c: cover property (@(posedge mclk_i) disable iff (rst_i) $fell(int_n_o));
  irq_gone_c: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(int_n_o));
  split_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    cu_src == 2'b11 && buf_wr_en_o);
  ready_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    flag[2]);
  slip_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    flag[1]);
endmodule

// ==== xrs_host_model.sv ====
// Purpose: host processor model driving the register port
// Assumes: single-byte accesses, one per call, launched just after an edge
// Notes: address is inverted on release so stale values never look valid
`timescale 1ns/1ps
module xrs_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  // idle bus from time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'hff;
    reg_wdata_o = 8'h00;
  end
  // one byte write, taken at the edge after it is raised
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge mclk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
  endtask
  // one byte read; data is registered, so it is picked up a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge mclk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge mclk_i);
    #1 d = reg_rdata_i;
  endtask
endmodule

// ==== xmit_resampler_status_irq_tb.sv ====
// Purpose: self-checking bench for the status and interrupt block
// Assumes: host model owns the register port; bench drives events
// Notes: event inputs pass a synchroniser, so waits leave eight cycles
`timescale 1ns/1ps
module xmit_resampler_status_irq_tb;
  import xrs_pkg::*;
  logic mclk_i, rst_i, rd_w, wr_w, hbw, cbw, rx_v, int_n, tx_v, byp, ben, bhost, cdis;
  logic [7:0] addr, wdata, rdata, idx;
  logic [5:0] cnd;
  logic [3:0] lrx;
  int error_cnt = 0;
  int total_checks = 0;
  xrs_host_model host (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_wr_o(wr_w),
    .reg_rd_o(rd_w), .reg_addr_o(addr), .reg_wdata_o(wdata));
  xrs_status_irq uut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(wr_w), .reg_rd_i(rd_w),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .copy_done_i(cnd[0]),
    .data_slip_i(cnd[1]), .block_start_i(cnd[2]), .est_in_done_i(cnd[3]),
    .est_out_done_i(cnd[4]), .rate_in_gt_out_i(cnd[5]), .buf_byte_idx_i(idx),
    .host_buf_wr_i(hbw), .capture_buf_wr_i(cbw), .buf_wr_en_o(ben),
    .buf_from_host_o(bhost), .rx_validity_i(rx_v), .line_rx_i(lrx), .tx_validity_o(tx_v),
    .bypass_data_o(byp), .copy_disable_o(cdis), .int_n_o(int_n));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // reset values, write masks, read-only and unmapped places
  task automatic t_regs();
    logic [7:0] ra[5] = '{8'h09, 8'h0b, 8'h0c, 8'h0a, 8'h20};
    logic [7:0] re[5] = '{8'h07, 8'h33, 8'h96, 8'h00, 8'h00};
    // trigger mode code 11 is reserved and the host must not pick it, so that register gets a legal mix
    logic [7:0] wv[5] = '{8'hff, 8'hff, 8'h96, 8'hff, 8'hff};
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      host.rd(ra[i], d);
      chk(d, 8'h00);
      host.wr(ra[i], wv[i]);
      host.rd(ra[i], d);
      chk(d, re[i]);
    end
    host.wr(ADDR_EVENT_MASK, 8'h00);
    host.wr(ADDR_EVENT_TRIG, 8'h00);
  endtask
  // every select code routes its own receiver line
  task automatic t_bypass();
    for (int s = 0; s < 4; s++) begin
      host.wr(ADDR_TX_CTRL2, {s[1:0], 6'h00});
      @(posedge mclk_i);
      lrx <= 4'h1 << s;
      cyc(3);
      chk({7'h0, byp}, 8'h01);
      @(posedge mclk_i);
      lrx <= ~(4'h1 << s);
      cyc(3);
      chk({7'h0, byp}, 8'h00);
    end
  endtask
  // control bit versus receiver passthrough
  task automatic t_valid();
    host.wr(ADDR_TX_CTRL1, 8'h02);
    host.wr(ADDR_TX_SRC_CFG, 8'h00);
    cyc(3);
    chk({7'h0, tx_v}, 8'h01);
    host.wr(ADDR_TX_SRC_CFG, 8'h04);
    cyc(3);
    chk({7'h0, tx_v}, 8'h00);
    @(posedge mclk_i);
    rx_v <= 1'b1;
    cyc(3);
    chk({7'h0, tx_v}, 8'h01);
    host.wr(ADDR_TX_CTRL1, 8'h00);
  endtask
  task automatic pl(input logic h, input logic [7:0] i, input logic e);
    @(posedge mclk_i);
    hbw <= h;
    cbw <= !h;
    idx <= i;
    @(posedge mclk_i);
    hbw <= 1'b0;
    cbw <= 1'b0;
    #1; // the gated strobe stands for this one cycle only
    chk({6'h0, ben & bhost, ben}, {6'h0, e & h, e});
  endtask
  // buffer writes per source code, both sides of the ten-byte split
  task automatic t_cu();
    for (int s = 0; s < 4; s++) begin
      host.wr(ADDR_TX_SRC_CFG, {6'h00, s[1:0]});
      pl(1'b1, 8'd9, s == 1 || s == 3);
      pl(1'b1, 8'd10, s == 1);
      pl(1'b0, 8'd9, s == 2);
      pl(1'b0, 8'd10, s == 2 || s == 3);
    end
  endtask
  // raise then drop a condition, judging flags, summary and interrupt
  task automatic ev(input logic [7:0] m, t, input logic [5:0] p, input logic [7:0] hi, lo, sm);
    logic [7:0] d;
    host.wr(ADDR_EVENT_MASK, m);
    host.wr(ADDR_EVENT_TRIG, t);
    @(posedge mclk_i);
    cnd <= p;
    cyc(8);
    chk({7'h0, int_n}, {7'h0, hi == 8'h00});
    host.rd(ADDR_SUMMARY, d);
    chk(d, sm);
    host.rd(ADDR_EVENT_STATUS, d);
    chk(d, hi);
    @(posedge mclk_i);
    cnd <= 6'h00;
    cyc(8);
    chk({7'h0, int_n}, {7'h0, lo == 8'h00});
    host.rd(ADDR_EVENT_STATUS, d);
    chk(d, lo);
  endtask
  task automatic t_events();
    ev(8'h01, 8'h00, 6'h01, 8'h01, 8'h00, 8'h01);
    ev(8'h02, 8'h04, 6'h02, 8'h00, 8'h02, 8'h00);
    ev(8'h10, 8'h20, 6'h18, 8'h10, 8'h00, 8'h02);
    ev(8'h10, 8'h20, 6'h08, 8'h00, 8'h00, 8'h00);
    ev(8'h20, 8'h00, 6'h20, 8'h20, 8'h00, 8'h02);
    ev(8'h20, 8'h40, 6'h20, 8'h00, 8'h20, 8'h00);
    ev(8'h00, 8'h00, 6'h3f, 8'h00, 8'h00, 8'h00);
    host.wr(ADDR_TX_CTRL1, 8'h01);
    ev(8'h02, 8'h00, 6'h02, 8'h00, 8'h00, 8'h00);
    ev(8'h02, 8'h00, 6'h04, 8'h02, 8'h00, 8'h01);
    host.wr(ADDR_TX_CTRL2, 8'h08);
    cyc(3);
    chk({7'h0, cdis}, 8'h01);
    ev(8'h01, 8'h00, 6'h01, 8'h00, 8'h00, 8'h00);
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // main sequence: hold reset for 20 cycles, then each scenario in turn
  initial begin
    rst_i = 1'b1;
    cnd = 6'h00;
    idx = 8'h00;
    hbw = 1'b0;
    cbw = 1'b0;
    rx_v = 1'b0;
    lrx = 4'h0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs();
    t_bypass();
    t_valid();
    t_cu();
    t_events();
    complete_run();
  end
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    complete_run();
  end
endmodule
